/* File: logic/itcc_pkg.sv */
// constants, field layout and mode enumeration of the interval timer channel
// assumes nothing beyond a SystemVerilog compiler
package itcc_pkg;

    // ****************************************
    // bus addresses and setup byte layout
    // ****************************************
    localparam logic [1:0] ITCC_ADDR_SETUP = 2'h3;
    localparam int         ITCC_SC_MSB     = 7;
    localparam int         ITCC_SC_LSB     = 6;
    localparam int         ITCC_FMT_MSB    = 5;
    localparam int         ITCC_FMT_LSB    = 4;
    localparam int         ITCC_MODE_MSB   = 3;
    localparam int         ITCC_MODE_LSB   = 1;
    localparam int         ITCC_BCD_BIT    = 0;

    // ****************************************
    // access format codes
    // ****************************************
    localparam logic [1:0] ITCC_FMT_LATCH = 2'h0;
    localparam logic [1:0] ITCC_FMT_LOW   = 2'h1;
    localparam logic [1:0] ITCC_FMT_HIGH  = 2'h2;
    localparam logic [1:0] ITCC_FMT_BOTH  = 2'h3;

    // ****************************************
    // values after reset and counter constants
    // ****************************************
    localparam logic [1:0]  ITCC_RST_FMT = 2'h3;
    localparam logic        ITCC_RST_OUT = 1'b1;
    localparam logic [15:0] ITCC_CNT_ONE = 16'h0001;
    localparam logic [15:0] ITCC_CNT_TWO = 16'h0002;
    localparam logic [1:0]  ITCC_STEP_1  = 2'h1;
    localparam logic [1:0]  ITCC_STEP_2  = 2'h2;
    localparam logic [1:0]  ITCC_STEP_3  = 2'h3;

    // ****************************************
    // positions in the synchronised pin vector
    // ****************************************
    localparam int ITCC_PIN_DATA = 0;
    localparam int ITCC_PIN_ADDR = 8;
    localparam int ITCC_PIN_WR   = 10;
    localparam int ITCC_PIN_RD   = 11;
    localparam int ITCC_PIN_CS   = 12;
    localparam int ITCC_PIN_CCLK = 13;
    localparam int ITCC_PIN_GATE = 14;
    localparam int ITCC_PIN_W    = 15;

    // ****************************************
    // counting modes, one-hot
    // ****************************************
    typedef enum logic [5:0] {
        ITCC_M0 = 6'h01,
        ITCC_M1 = 6'h02,
        ITCC_M2 = 6'h04,
        ITCC_M3 = 6'h08,
        ITCC_M4 = 6'h10,
        ITCC_M5 = 6'h20
    } itcc_mode_t;

    // three-bit mode field to mode, top bit ignored for x10 and x11
    function automatic itcc_mode_t itcc_decode_mode(input logic [2:0] f);
        case (f)
            3'h0:    return ITCC_M0;
            3'h1:    return ITCC_M1;
            3'h4:    return ITCC_M4;
            3'h5:    return ITCC_M5;
            default: return f[0] ? ITCC_M3 : ITCC_M2;
        endcase
    endfunction

endpackage

/* File: logic/itcc_edge_if.sv */
// level and edge strobes of synchronised pins
// assumes one producer and one consumer on the same clock
`timescale 1ns/1ps
interface itcc_edge_if #(parameter int W = 1) ();
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    modport src (output lvl, output rise, output fall);
    modport dst (input lvl, input rise, input fall);
endinterface

/* File: logic/itcc_pin_sync.sv */
// two-flop synchroniser with edge strobes for a vector of pins
// assumes pins are asynchronous to clk_in
`timescale 1ns/1ps
module itcc_pin_sync
    import itcc_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic [W-1:0] pin_in,
    itcc_edge_if.src          edge_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
        logic [W-1:0] prev;
    } itcc_sync_st_t;

    itcc_sync_st_t q;
    itcc_sync_st_t d;

    // ****************************************
    // shift chain, meta read only by stab
    // ****************************************
    always_comb begin
        d      = q;
        d.meta = pin_in;
        d.stab = q.meta;
        d.prev = q.stab;
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    // level and one-cycle edge strobes
    assign edge_o.lvl  = q.stab;
    assign edge_o.rise = q.stab & ~q.prev;
    assign edge_o.fall = ~q.stab & q.prev;

endmodule

/* File: logic/itcc_decrement.sv */
// subtracts a step of 0..3 from a count, binary or four bcd digits
// assumes a purely combinational use
`timescale 1ns/1ps
module itcc_decrement
    import itcc_pkg::*;
(
    input  wire logic [15:0] value_in,
    input  wire logic [1:0]  step_in,
    input  wire logic        bcd_in,
    output logic      [15:0] value_out
);

    logic [3:0]  sub [0:4];
    logic [15:0] bcd_val;

    assign sub[0] = {2'h0, step_in};

    // ****************************************
    // per digit subtract with borrow chain
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_digit
            logic [5:0] diff;
            logic [5:0] fix;
            assign diff = {2'h0, value_in[4*i +: 4]} - {2'h0, sub[i]};
            assign fix  = diff + 6'h0A;
            assign bcd_val[4*i +: 4] = diff[5] ? fix[3:0] : diff[3:0];
            assign sub[i+1] = {3'h0, diff[5]};
        end
    endgenerate

    // binary or decimal result
    assign value_out = bcd_in ? bcd_val : value_in - {14'h0000, step_in};

endmodule

/* File: logic/itcc_channel.sv */
// one channel of a programmable interval timer with its byte-wide host port
// assumes host pins and count clock are asynchronous to REF_CLK_IN;
// host holds CS, address and data at least 3 reference clocks past WR rising
//
// Contract
// - access format 00 latch, 10 high byte, 01 low byte, 11 low then high
// - number base bit selects binary or four-digit bcd decrement
// - new count taken after all bytes, a count clock rise, then fall
// - mode 0: output low at setup and count, high at terminal count
// - mode 0: counter keeps decrementing after terminal count
// - mode 0: first byte halts counting, second byte starts new count
// - mode 1: output drops after gate rising, high again at terminal count
// - mode 1: new count applies at next trigger, reads leave pulse alone
// - mode 1: each gate rising edge retriggers the full count
// - mode 2: divide by n, output low one clock every n clocks
// - mode 2: reload between pulses affects only the following period
// - mode 2: gate low forces output high, gate rising restarts count
// - mode 2: output high after setup until a count is loaded
// - mode 3: even count steps by two, toggles and reloads at terminal
// - mode 3: odd count first step one when high, three when low
// - mode 4: high after setup, count on load, one clock low at terminal
// - mode 4: rewritten count loads on next count clock
// - mode 4: counting stops while gate is low
// - mode 5: counting starts at gate rising, one clock low at terminal
// - mode 5: each trigger restarts the full count
// - setup byte: channel pick, access format, mode, number base
// - mode 1: gate rising starts counting, output low after next clock
`timescale 1ns/1ps
module itcc_channel
    import itcc_pkg::*;
#(
    parameter logic [1:0] CHANNEL_ID = 2'h0
) (
    input  wire logic       REF_CLK_IN,
    input  wire logic       RST_B_IN,
    input  wire logic       CS_B_IN,
    input  wire logic       RD_B_IN,
    input  wire logic       WR_B_IN,
    input  wire logic [1:0] ADDR_IN,
    input  wire logic [7:0] DATA_IN,
    output logic      [7:0] DATA_OUT,
    output logic            DATA_OE_OUT,
    input  wire logic       CNT_CLK_IN,
    input  wire logic       GATE_IN,
    output logic            TIMER_OUT
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        itcc_mode_t  mode;
        logic [1:0]  fmt;
        logic        bcd;
        logic [15:0] count;
        logic [15:0] reload;
        logic [15:0] latch;
        logic        latched;
        logic        wr_hi;
        logic        rd_hi;
        logic        pend;
        logic        arm;
        logic        running;
        logic        have_count;
        logic        first;
        logic        trig;
        logic        out;
        logic        oe;
        logic [7:0]  dout;
    } itcc_chan_st_t;

    localparam itcc_chan_st_t ITCC_RST_ST = '{
        mode: ITCC_M0, fmt: ITCC_RST_FMT, out: ITCC_RST_OUT, default: '0};

    itcc_chan_st_t q;
    itcc_chan_st_t d;

    // ****************************************
    // pin synchronisation
    // ****************************************
    itcc_edge_if #(.W(ITCC_PIN_W)) pins ();
    logic [ITCC_PIN_W-1:0] pin_vec;

    assign pin_vec = {GATE_IN, CNT_CLK_IN, CS_B_IN, RD_B_IN, WR_B_IN, ADDR_IN, DATA_IN};

    itcc_pin_sync #(.W(ITCC_PIN_W)) u_sync (
        .clk_in   (REF_CLK_IN),
        .rst_b_in (RST_B_IN),
        .pin_in   (pin_vec),
        .edge_o   (pins.src)
    );

    // decoded host strobes and count clock edges
    logic [7:0] bus_data;
    logic [1:0] bus_addr;
    logic       bus_cs;
    logic       wr_evt;
    logic       setup_wr;
    logic       cnt_wr;
    logic       rd_sel;
    logic       rd_end;
    logic       cnt_rise;
    logic       cnt_fall;
    logic       gate_lvl;
    logic       gate_rise;
    logic       ld;
    itcc_mode_t new_mode;

    assign bus_data  = pins.lvl[ITCC_PIN_DATA +: 8];
    assign bus_addr  = pins.lvl[ITCC_PIN_ADDR +: 2];
    assign bus_cs    = ~pins.lvl[ITCC_PIN_CS];
    assign wr_evt    = pins.rise[ITCC_PIN_WR] & bus_cs;
    assign setup_wr  = wr_evt && bus_addr == ITCC_ADDR_SETUP
                       && bus_data[ITCC_SC_MSB:ITCC_SC_LSB] == CHANNEL_ID;
    assign cnt_wr    = wr_evt && bus_addr == CHANNEL_ID;
    assign rd_sel    = bus_cs && !pins.lvl[ITCC_PIN_RD] && bus_addr == CHANNEL_ID;
    assign rd_end    = pins.rise[ITCC_PIN_RD] && bus_cs && bus_addr == CHANNEL_ID;
    assign cnt_rise  = pins.rise[ITCC_PIN_CCLK];
    assign cnt_fall  = pins.fall[ITCC_PIN_CCLK];
    assign gate_lvl  = pins.lvl[ITCC_PIN_GATE];
    assign gate_rise = pins.rise[ITCC_PIN_GATE];
    assign ld        = cnt_fall & q.arm;
    assign new_mode  = itcc_decode_mode(bus_data[ITCC_MODE_MSB:ITCC_MODE_LSB]);

    // ****************************************
    // decrement step and shared subtractor
    // ****************************************
    logic [1:0]  step;
    logic [15:0] dec;
    logic        tc1;

    // mode 3 steps by two, odd counts start with one or three
    always_comb begin
        step = ITCC_STEP_1;
        if (q.mode == ITCC_M3) begin
            step = ITCC_STEP_2;
            if (q.reload[0] && q.first) begin
                step = q.out ? ITCC_STEP_1 : ITCC_STEP_3;
            end
        end
    end

    itcc_decrement u_dec (
        .value_in  (q.count),
        .step_in   (step),
        .bcd_in    (q.bcd),
        .value_out (dec)
    );

    assign tc1 = q.count == ITCC_CNT_ONE;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [7:0]  rbyte;
        logic [15:0] src;
        logic        done;
        rbyte = 8'h00;
        src   = 16'h0000;
        done  = 1'b0;
        d     = q;

        // count write only takes effect after a rise then a fall
        if (cnt_rise && q.pend) begin
            d.pend = 1'b0;
            d.arm  = 1'b1;
        end
        if (ld) begin
            d.arm = 1'b0;
        end

        // counting on the falling edge of the count clock
        if (cnt_fall) begin
            d.trig = 1'b0;
            case (q.mode)
                ITCC_M0: begin
                    if (ld) begin
                        d.count   = q.reload;
                        d.running = 1'b1;
                        d.out     = 1'b0;
                    end else if (q.running && gate_lvl) begin
                        d.count = dec;
                        if (tc1) begin
                            d.out = 1'b1;
                        end
                    end
                end
                ITCC_M1: begin
                    if (q.trig && q.have_count) begin
                        d.count   = q.reload;
                        d.running = 1'b1;
                        d.out     = 1'b0;
                    end else if (q.running) begin
                        d.count = dec;
                        if (tc1) begin
                            d.out = 1'b1;
                        end
                    end
                end
                ITCC_M2: begin
                    if ((q.trig || (ld && !q.running)) && q.have_count && gate_lvl) begin
                        d.count   = q.reload;
                        d.running = 1'b1;
                        d.out     = 1'b1;
                    end else if (q.running && gate_lvl) begin
                        if (tc1) begin
                            d.count = q.reload;
                            d.out   = 1'b1;
                        end else begin
                            d.count = dec;
                            d.out   = q.count != ITCC_CNT_TWO;
                        end
                    end
                end
                ITCC_M3: begin
                    if ((q.trig || (ld && !q.running)) && q.have_count && gate_lvl) begin
                        d.count   = q.reload;
                        d.running = 1'b1;
                        d.out     = 1'b1;
                        d.first   = 1'b1;
                    end else if (q.running && gate_lvl) begin
                        if (q.count == {14'h0000, step}) begin
                            d.count = q.reload;
                            d.out   = ~q.out;
                            d.first = 1'b1;
                        end else begin
                            d.count = dec;
                            d.first = 1'b0;
                        end
                    end
                end
                ITCC_M4: begin
                    if (ld) begin
                        d.count   = q.reload;
                        d.running = 1'b1;
                        d.out     = 1'b1;
                    end else if (q.running && gate_lvl) begin
                        if (!q.out) begin
                            d.out     = 1'b1;
                            d.running = 1'b0;
                        end else begin
                            d.count = dec;
                            d.out   = !tc1;
                        end
                    end
                end
                ITCC_M5: begin
                    if (q.trig && q.have_count) begin
                        d.count   = q.reload;
                        d.running = 1'b1;
                        d.out     = 1'b1;
                    end else if (q.running) begin
                        if (!q.out) begin
                            d.out     = 1'b1;
                            d.running = 1'b0;
                        end else begin
                            d.count = dec;
                            d.out   = !tc1;
                        end
                    end
                end
                default: begin
                    d.running = 1'b0;
                end
            endcase
        end

        // gate rising is sticky until the next falling count edge
        if (gate_rise) begin
            d.trig = 1'b1;
        end

        // low gate forces the rate outputs high at once
        if ((q.mode == ITCC_M2 || q.mode == ITCC_M3) && !gate_lvl) begin
            d.out = 1'b1;
        end

        // count byte writes in the selected access format
        if (cnt_wr) begin
            case (q.fmt)
                ITCC_FMT_LOW: begin
                    d.reload = {8'h00, bus_data};
                    done     = 1'b1;
                end
                ITCC_FMT_HIGH: begin
                    d.reload = {bus_data, 8'h00};
                    done     = 1'b1;
                end
                default: begin
                    if (!q.wr_hi) begin
                        d.reload[7:0] = bus_data;
                        d.wr_hi       = 1'b1;
                        if (q.mode == ITCC_M0) begin
                            d.running = 1'b0;
                        end
                    end else begin
                        d.reload[15:8] = bus_data;
                        d.wr_hi        = 1'b0;
                        done           = 1'b1;
                    end
                end
            endcase
            if (done) begin
                d.pend       = 1'b1;
                d.arm        = 1'b0;
                d.have_count = 1'b1;
            end
        end

        // setup byte: latch command or new mode
        if (setup_wr) begin
            if (bus_data[ITCC_FMT_MSB:ITCC_FMT_LSB] == ITCC_FMT_LATCH) begin
                d.latch   = q.count;
                d.latched = 1'b1;
            end else begin
                d.mode       = new_mode;
                d.fmt        = bus_data[ITCC_FMT_MSB:ITCC_FMT_LSB];
                d.bcd        = bus_data[ITCC_BCD_BIT];
                d.running    = 1'b0;
                d.pend       = 1'b0;
                d.arm        = 1'b0;
                d.wr_hi      = 1'b0;
                d.rd_hi      = 1'b0;
                d.latched    = 1'b0;
                d.have_count = 1'b0;
                d.out        = new_mode != ITCC_M0;
            end
        end

        // read byte from snapshot or live count
        src = q.latched ? q.latch : q.count;
        case (q.fmt)
            ITCC_FMT_HIGH: rbyte = src[15:8];
            ITCC_FMT_LOW:  rbyte = src[7:0];
            default:       rbyte = q.rd_hi ? src[15:8] : src[7:0];
        endcase
        d.dout = rbyte;
        d.oe   = rd_sel;
        if (rd_end) begin
            if (q.fmt == ITCC_FMT_BOTH) begin
                d.rd_hi = ~q.rd_hi;
            end
            if (q.fmt != ITCC_FMT_BOTH || q.rd_hi) begin
                d.latched = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            q <= ITCC_RST_ST;
        end else begin
            q <= d;
        end
    end

    assign DATA_OUT    = q.dout;
    assign DATA_OE_OUT = q.oe;
    assign TIMER_OUT   = q.out;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    property p_fmt_latch;
        setup_wr && bus_data[ITCC_FMT_MSB:ITCC_FMT_LSB] == ITCC_FMT_LATCH
            |=> q.latched && q.latch == $past(q.count);
    endproperty
    a_fmt_latch: assert property (p_fmt_latch) else $error("latch snapshot wrong");

    property p_load_wait;
        q.pend && !q.arm && !cnt_rise && !setup_wr && !cnt_wr |=> !q.arm && q.pend;
    endproperty
    a_load_wait: assert property (p_load_wait) else $error("load armed without count clock rise");

    property p_m0_setup;
        setup_wr && bus_data[ITCC_FMT_MSB:ITCC_FMT_LSB] != ITCC_FMT_LATCH && new_mode == ITCC_M0
            |=> !q.out && !q.running;
    endproperty
    a_m0_setup: assert property (p_m0_setup) else $error("mode 0 output not low after setup");

    property p_m0_tc;
        q.mode == ITCC_M0 && q.running && cnt_fall && gate_lvl && !q.arm && tc1 && !cnt_wr && !setup_wr
            |=> q.out && q.count == 16'h0000 && q.running;
    endproperty
    a_m0_tc: assert property (p_m0_tc) else $error("mode 0 terminal count wrong");

    property p_m0_halt;
        q.mode == ITCC_M0 && q.fmt == ITCC_FMT_BOTH && !q.wr_hi && cnt_wr && !setup_wr
            |=> !q.running && q.wr_hi;
    endproperty
    a_m0_halt: assert property (p_m0_halt) else $error("first byte did not halt mode 0");

    property p_m2_pulse;
        q.mode == ITCC_M2 && q.running && cnt_fall && gate_lvl && !q.trig && tc1 && !cnt_wr && !setup_wr
            |=> q.out && q.count == q.reload;
    endproperty
    a_m2_pulse: assert property (p_m2_pulse) else $error("mode 2 reload wrong");

    property p_m2_gate;
        q.mode == ITCC_M2 && !gate_lvl && !setup_wr |=> q.out;
    endproperty
    a_m2_gate: assert property (p_m2_gate) else $error("mode 2 low gate must force high");

    property p_m2_setup;
        setup_wr && bus_data[ITCC_FMT_MSB:ITCC_FMT_LSB] != ITCC_FMT_LATCH && new_mode == ITCC_M2
            |=> q.out && !q.running && !q.have_count;
    endproperty
    a_m2_setup: assert property (p_m2_setup) else $error("mode 2 not high after setup");

    property p_m3_even;
        q.mode == ITCC_M3 && q.running && cnt_fall && gate_lvl && !q.bcd && !q.reload[0]
            && q.count != ITCC_CNT_TWO && !q.trig && !cnt_wr && !setup_wr
            |=> q.count == $past(q.count) - ITCC_CNT_TWO;
    endproperty
    a_m3_even: assert property (p_m3_even) else $error("mode 3 even step not two");

    property p_m4_gate;
        q.mode == ITCC_M4 && !gate_lvl && cnt_fall && !q.arm && !setup_wr && !cnt_wr |=> $stable(q.count);
    endproperty
    a_m4_gate: assert property (p_m4_gate) else $error("mode 4 counted with gate low");

    c_m0_tc: cover property (q.mode == ITCC_M0 && $rose(q.out));
    c_m3_tog: cover property (q.mode == ITCC_M3 && $fell(q.out));
    c_m5_strobe: cover property (q.mode == ITCC_M5 && $rose(q.out) && !q.running);

endmodule

/* File: bench/itcc_host_model.sv */
// host bus model writing setup and count bytes
// assumes the channel samples its pins on CLK_IN
`timescale 1ns/1ps
module itcc_host_model (
    input  wire logic       CLK_IN,
    output logic            CS_B_OUT,
    output logic            RD_B_OUT,
    output logic            WR_B_OUT,
    output logic      [1:0] ADDR_OUT,
    output logic      [7:0] DATA_OUT
);
    // bus idle at start
    initial begin
        CS_B_OUT = 1'b1;
        RD_B_OUT = 1'b1;
        WR_B_OUT = 1'b1;
        ADDR_OUT = 2'h0;
        DATA_OUT = 8'h5A;
    end
    // one strobe, select and data held past its release
    task automatic access(input logic wr, input logic [1:0] a, input logic [7:0] d);
        @(negedge CLK_IN);
        CS_B_OUT = 1'b0;
        ADDR_OUT = a;
        DATA_OUT = d;
        WR_B_OUT = !wr;
        RD_B_OUT = wr;
        repeat (8) @(negedge CLK_IN);
        WR_B_OUT = 1'b1;
        RD_B_OUT = 1'b1;
        repeat (4) @(negedge CLK_IN);
        CS_B_OUT = 1'b1;
        DATA_OUT = ~d;
        repeat (4) @(negedge CLK_IN);
    endtask
endmodule

/* File: bench/itcc_channel_tb.sv */
// self-checking bench for the timer channel
// assumes the host model drives the bus pins
`timescale 1ns/1ps
module itcc_channel_tb;
    import itcc_pkg::*;
    logic       clk, rst_b, cclk, gate, cs_b, rd_b, wr_b, oe, tout, oe_q;
    logic [1:0] addr;
    logic [7:0] din, dout, dq[$];
    logic       tq[$];
    int         fail_count, num_checks, seed, cycles, n1, n2;
    itcc_channel itcc_channel_inst (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .CS_B_IN(cs_b), .RD_B_IN(rd_b),
        .WR_B_IN(wr_b), .ADDR_IN(addr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_OUT(oe),
        .CNT_CLK_IN(cclk), .GATE_IN(gate), .TIMER_OUT(tout));
    itcc_host_model itcc_host_model_inst (.CLK_IN(clk), .CS_B_OUT(cs_b), .RD_B_OUT(rd_b),
        .WR_B_OUT(wr_b), .ADDR_OUT(addr), .DATA_OUT(din));
    // reference clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string s, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // read byte compared when data drive starts
    always @(negedge clk) begin
        oe_q <= oe;
        if (oe === 1'b1 && oe_q !== 1'b1) check("rd", dout, dq.pop_front());
    end
    // output compared at each count clock rise that has a queued note
    always @(posedge cclk) if (tq.size() > 0) check("out", {7'h0, tout}, {7'h0, tq.pop_front()});
    // hang limit
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic tick(input logic e);
        @(negedge clk) cclk = 1'b1;
        repeat (6) @(negedge clk);
        cclk = 1'b0;
        tq.push_back(e);
        repeat (6) @(negedge clk);
    endtask
    // count clock cycle that checks the last note and leaves none
    task automatic flush();
        @(negedge clk) cclk = 1'b1;
        repeat (6) @(negedge clk);
        cclk = 1'b0;
        repeat (6) @(negedge clk);
    endtask
    task automatic period(input int n);
        for (int k = n - 1; k > 0; k--) tick(k != 1);
        tick(1'b1);
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        itcc_host_model_inst.access(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] e);
        dq.push_back(e);
        itcc_host_model_inst.access(1'b0, 2'h0, 8'h00);
    endtask
    function automatic logic [7:0] setup(input logic [1:0] f, input logic [2:0] m, input logic b);
        return {2'h0, f, m, b};
    endfunction
    // mode 0 binary and bcd, latch reads, mode 2 random counts and gate, mode 4
    initial begin
        seed = 46;
        rst_b = 1'b0;
        cclk = 1'b0;
        gate = 1'b1;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        wr(ITCC_ADDR_SETUP, setup(ITCC_FMT_BOTH, 3'h0, 1'b0));
        tick(1'b0);
        wr(2'h0, 8'h02);
        wr(2'h0, 8'h00);
        tick(1'b0);
        tick(1'b0);
        tick(1'b1);
        tick(1'b1);
        wr(ITCC_ADDR_SETUP, setup(ITCC_FMT_LATCH, 3'h0, 1'b0));
        rd(8'hFF);
        rd(8'hFF);
        flush();
        wr(ITCC_ADDR_SETUP, setup(ITCC_FMT_BOTH, 3'h0, 1'b1));
        wr(2'h0, 8'h00);
        wr(2'h0, 8'h10);
        tick(1'b0);
        tick(1'b0);
        wr(ITCC_ADDR_SETUP, setup(ITCC_FMT_LATCH, 3'h0, 1'b0));
        rd(8'h99);
        rd(8'h09);
        flush();
        n1 = 2 + ($random(seed) & 3);
        n2 = 2 + ($random(seed) & 3);
        wr(ITCC_ADDR_SETUP, setup(ITCC_FMT_LOW, 3'h6, 1'b0));
        tick(1'b1);
        wr(2'h0, n1[7:0]);
        gate = 1'b0;
        repeat (4) @(negedge clk);
        gate = 1'b1;
        tick(1'b1);
        wr(2'h0, n2[7:0]);
        period(n1);
        period(n2);
        gate = 1'b0;
        tick(1'b1);
        gate = 1'b1;
        tick(1'b1);
        period(n2);
        wr(ITCC_ADDR_SETUP, setup(ITCC_FMT_LOW, 3'h4, 1'b0));
        wr(2'h0, 8'h02);
        tick(1'b1);
        gate = 1'b0;
        tick(1'b1);
        gate = 1'b1;
        tick(1'b1);
        tick(1'b0);
        tick(1'b1);
        @(negedge clk) cclk = 1'b1;
        repeat (20) @(negedge clk);
        check("left", 8'(dq.size() + tq.size()), 8'h00);
        complete_run();
    end
endmodule
